/* mcu_core_regs.svh */
// Constants for the core register file and memory map
`ifndef MCU_CORE_REGS_SVH
`define MCU_CORE_REGS_SVH
// ----------------------------------------
// Special register addresses
// ----------------------------------------
`define SFR_ACC      8'he0
`define SFR_AUX      8'hf0
`define SFR_FLAGS    8'hd0
`define SFR_STACK    8'h81
`define SFR_DP_LOW   8'h82
`define SFR_DP_HIGH  8'h83
`define SFR_PAGE     8'ha1
`define SFR_MAP      8'ha2
// ----------------------------------------
// Fields of the flags word
// ----------------------------------------
`define FLG_CY       7
`define FLG_AC       6
`define FLG_RS_HI    4
`define FLG_RS_LO    3
`define FLG_OV       2
`define FLG_PAR      0
// ----------------------------------------
// Reset values and fixed locations
// ----------------------------------------
`define RST_STACK    8'h07
`define RST_BYTE     8'h00
`define RST_FETCH    16'h0000
`define BIT_BASE     8'h20
`define VEC_BASE     16'h0003
`define VEC_SHIFT    3
`endif

/* mcu_core_pkg.sv */
// Types shared by the core register file
package mcu_core_pkg;
  typedef struct packed {
    logic       en;
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } byte_req_t;
  typedef struct packed {
    logic       en;
    logic       we;
    logic [2:0] idx;
    logic [7:0] wdata;
  } reg_req_t;
  typedef struct packed {
    logic       en;
    logic       we;
    logic [7:0] addr;
    logic       val;
  } bit_req_t;
  typedef struct packed {
    logic cy_upd;
    logic cy;
    logic ac_upd;
    logic ac;
    logic ov_upd;
    logic ov;
  } alu_flags_t;
endpackage

/* mcu_core_memory_and_registers.sv */
// Register file, internal RAM and address generation of the 8-bit core
`include "mcu_core_regs.svh"
// How it works
// - Separate 64KB code and data address outputs
// - Code writes pass only while programming
// - 256-byte read/write RAM holds the stack
// - Upper 128 special registers: direct only
// - Accumulator pairs with aux as 16 bits
// - Stack pointer increments before each push
// - Stack pointer resets to 07h
// - Fetch counter 16 bits, resets to 0000h
// - Carry takes ALU carry or shift bit
// - Nibble carry takes bit 3 carry
// - Two bank bits choose active bank
// - Signed range flag set on overflow
// - Parity bit keeps ones count even
// - Data pointer: 16 bits, two bytes
// - Taken interrupt loads its vector
// - Vectors at 0003h, eight bytes apart
// - Unused vectors stay plain code memory
// - Four banks in bytes 0 to 31
// - Bytes 20h-2Fh hold 128 bits
// - Special registers ending 0h/8h bit-addressable
// - Page register extends beyond 64K
// - Either flash array mappable into data
module mcu_core_memory_and_registers
  import mcu_core_pkg::*;
#(
  parameter int RAM_DEPTH = 256,
  parameter int SRC_BITS  = 3
) (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                sys_rst,
  // Operand access
  input  wire byte_req_t           dir_req,
  input  wire byte_req_t           ind_req,
  input  wire reg_req_t            reg_req,
  input  wire bit_req_t            bit_req,
  output logic [7:0]               dir_rdata,
  output logic [7:0]               ind_rdata,
  output logic [7:0]               reg_rdata,
  output logic                     bit_rdata,
  // Stack
  input  wire logic                push,
  input  wire logic                pop,
  input  wire logic [7:0]          push_data,
  output logic [7:0]               pop_data,
  // Execution results
  input  wire logic                acc_wr,
  input  wire logic [7:0]          acc_wdata,
  input  wire logic                ab_wr,
  input  wire logic [15:0]         ab_wdata,
  input  wire alu_flags_t          alu_flags,
  input  wire logic                ext_data_pointer_inc,
  // Fetch control
  input  wire logic                pc_inc,
  input  wire logic                pc_load,
  input  wire logic [15:0]         pc_load_addr,
  input  wire logic                irq_take,
  input  wire logic [SRC_BITS-1:0] irq_src,
  // Memory side
  input  wire logic                flash_prog,
  input  wire logic                code_we_req,
  output logic                     code_we,
  output logic                     code_wr_refused,
  output logic [15:0]              fetch_addr,
  output logic [15:0]              ext_data_addr,
  output logic [7:0]               ext_page,
  output logic                     main_in_data,
  output logic                     sec_in_data
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0] ram_r [RAM_DEPTH];
  logic [7:0] acc_r, aux_r, sp_r, flags_r;
  logic [7:0] dpl_r, dph_r, pch_r, pcl_r;
  logic [7:0] page_r;
  logic [1:0] map_r;
  logic [7:0] flags_full, flags_nxt;
  logic       sfr_we, ram_we;
  logic [7:0] sfr_wa, sfr_wd, ram_wa, ram_wd;
  logic [7:0] bit_byte, bit_old;
  logic       refused_r;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic [7:0] bit_home(input logic [7:0] a);
    if (a[7]) begin
      bit_home = {a[7:3], 3'h0};
    end else begin
      bit_home = `BIT_BASE + {4'h0, a[6:3]};
    end
  endfunction

  function automatic logic [7:0] bank_addr(input logic [1:0] rs,
                                           input logic [2:0] idx);
    bank_addr = {3'h0, rs, idx};
  endfunction

  function automatic logic [7:0] sfr_rd(input logic [7:0] a);
    case (a)
      `SFR_ACC:     sfr_rd = acc_r;
      `SFR_AUX:     sfr_rd = aux_r;
      `SFR_FLAGS:   sfr_rd = flags_full;
      `SFR_STACK:   sfr_rd = sp_r;
      `SFR_DP_LOW:  sfr_rd = dpl_r;
      `SFR_DP_HIGH: sfr_rd = dph_r;
      `SFR_PAGE:    sfr_rd = page_r;
      `SFR_MAP:     sfr_rd = {6'h00, map_r};
      default:      sfr_rd = 8'h00;
    endcase
  endfunction

  // Parity is computed, so software writes to it have no effect
  assign flags_full = {flags_r[7:1], ^acc_r};
  assign bit_byte   = bit_home(bit_req.addr);

  // A process, so a change of a register read inside sfr_rd re-evaluates
  always_comb begin
    bit_old = bit_req.addr[7] ? sfr_rd(bit_byte) : ram_r[bit_byte];
  end

  // ----------------------------------------
  // Write steering
  // ----------------------------------------
  always_comb begin
    sfr_we = 1'b0;
    sfr_wa = dir_req.addr;
    sfr_wd = dir_req.wdata;
    if (dir_req.en && dir_req.we && dir_req.addr[7]) begin
      sfr_we = 1'b1;
    end else if (bit_req.en && bit_req.we && bit_req.addr[7]) begin
      sfr_we = 1'b1;
      sfr_wa = bit_byte;
      sfr_wd = bit_old;
      sfr_wd[bit_req.addr[2:0]] = bit_req.val;
    end
  end

  // Only one access per cycle is expected; this order settles clashes
  always_comb begin
    ram_we = 1'b0;
    ram_wa = 8'h00;
    ram_wd = 8'h00;
    if (push) begin
      ram_we = 1'b1;
      ram_wa = sp_r + 8'h01;
      ram_wd = push_data;
    end else if (dir_req.en && dir_req.we && !dir_req.addr[7]) begin
      ram_we = 1'b1;
      ram_wa = dir_req.addr;
      ram_wd = dir_req.wdata;
    end else if (ind_req.en && ind_req.we) begin
      ram_we = 1'b1;
      ram_wa = ind_req.addr;
      ram_wd = ind_req.wdata;
    end else if (reg_req.en && reg_req.we) begin
      ram_we = 1'b1;
      ram_wa = bank_addr(flags_r[`FLG_RS_HI:`FLG_RS_LO], reg_req.idx);
      ram_wd = reg_req.wdata;
    end else if (bit_req.en && bit_req.we && !bit_req.addr[7]) begin
      ram_we = 1'b1;
      ram_wa = bit_byte;
      ram_wd = bit_old;
      ram_wd[bit_req.addr[2:0]] = bit_req.val;
    end
  end

  // ----------------------------------------
  // Internal RAM
  // ----------------------------------------
  // Contents are left as they are across reset
  always_ff @(posedge core_clk) begin
    if (ram_we) begin
      ram_r[ram_wa] <= ram_wd;
    end
  end

  // ----------------------------------------
  // Accumulator and aux register
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      acc_r <= `RST_BYTE;
      aux_r <= `RST_BYTE;
    end else if (ab_wr) begin
      {aux_r, acc_r} <= ab_wdata;
    end else begin
      if (acc_wr) begin
        acc_r <= acc_wdata;
      end else if (sfr_we && sfr_wa == `SFR_ACC) begin
        acc_r <= sfr_wd;
      end
      if (sfr_we && sfr_wa == `SFR_AUX) begin
        aux_r <= sfr_wd;
      end
    end
  end

  // ----------------------------------------
  // Stack pointer
  // ----------------------------------------
  // Wraps modulo 256; no overflow is flagged
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sp_r <= `RST_STACK;
    end else if (push) begin
      sp_r <= sp_r + 8'h01;
    end else if (pop) begin
      sp_r <= sp_r - 8'h01;
    end else if (sfr_we && sfr_wa == `SFR_STACK) begin
      sp_r <= sfr_wd;
    end
  end

  // ----------------------------------------
  // Flags word
  // ----------------------------------------
  // ALU updates win over a software write in the same cycle
  always_comb begin
    flags_nxt = flags_r;
    if (sfr_we && sfr_wa == `SFR_FLAGS) begin
      flags_nxt = sfr_wd;
    end
    if (alu_flags.cy_upd) begin
      flags_nxt[`FLG_CY] = alu_flags.cy;
    end
    if (alu_flags.ac_upd) begin
      flags_nxt[`FLG_AC] = alu_flags.ac;
    end
    if (alu_flags.ov_upd) begin
      flags_nxt[`FLG_OV] = alu_flags.ov;
    end
    flags_nxt[`FLG_PAR] = 1'b0;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      flags_r <= `RST_BYTE;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // ----------------------------------------
  // Data pointer, page and map
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      {dph_r, dpl_r} <= {`RST_BYTE, `RST_BYTE};
    end else if (ext_data_pointer_inc) begin
      {dph_r, dpl_r} <= {dph_r, dpl_r} + 16'h0001;
    end else if (sfr_we && sfr_wa == `SFR_DP_LOW) begin
      dpl_r <= sfr_wd;
    end else if (sfr_we && sfr_wa == `SFR_DP_HIGH) begin
      dph_r <= sfr_wd;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      page_r <= `RST_BYTE;
      map_r  <= 2'h0;
    end else if (sfr_we && sfr_wa == `SFR_PAGE) begin
      page_r <= sfr_wd;
    end else if (sfr_we && sfr_wa == `SFR_MAP) begin
      map_r <= sfr_wd[1:0];
    end
  end

  // ----------------------------------------
  // Fetch address counter
  // ----------------------------------------
  // Vectors are only jump targets; nothing guards their bytes
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      {pch_r, pcl_r} <= `RST_FETCH;
    end else if (irq_take) begin
      {pch_r, pcl_r} <= `VEC_BASE +
        (16'(irq_src) << `VEC_SHIFT);
    end else if (pc_load) begin
      {pch_r, pcl_r} <= pc_load_addr;
    end else if (pc_inc) begin
      {pch_r, pcl_r} <= {pch_r, pcl_r} + 16'h0001;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      dir_rdata <= 8'h00;
      ind_rdata <= 8'h00;
      reg_rdata <= 8'h00;
      bit_rdata <= 1'b0;
      pop_data  <= 8'h00;
    end else begin
      if (dir_req.en) begin
        dir_rdata <= dir_req.addr[7] ? sfr_rd(dir_req.addr)
                                     : ram_r[dir_req.addr];
      end
      if (ind_req.en) begin
        ind_rdata <= ram_r[ind_req.addr];
      end
      if (reg_req.en) begin
        reg_rdata <= ram_r[bank_addr(flags_r[`FLG_RS_HI:`FLG_RS_LO],
                                     reg_req.idx)];
      end
      if (bit_req.en) begin
        bit_rdata <= bit_old[bit_req.addr[2:0]];
      end
      if (pop) begin
        pop_data <= ram_r[sp_r];
      end
    end
  end

  // ----------------------------------------
  // Memory side outputs
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      refused_r <= 1'b0;
    end else begin
      refused_r <= code_we_req && !flash_prog;
    end
  end

  assign code_we         = code_we_req && flash_prog;
  assign code_wr_refused = refused_r;
  assign fetch_addr      = {pch_r, pcl_r};
  assign ext_data_addr   = {dph_r, dpl_r};
  assign ext_page        = page_r;
  assign main_in_data    = map_r[0];
  assign sec_in_data     = map_r[1];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_stack_reset: assert property (@(posedge core_clk)
    sys_rst |=> sp_r == 8'h07 && fetch_addr == 16'h0000)
    else $error("stack or fetch reset value wrong");

  a_push_pre_inc: assert property (@(posedge core_clk)
    disable iff (sys_rst) push |=>
      sp_r == $past(sp_r) + 8'h01 && ram_r[sp_r] == $past(push_data))
    else $error("push did not pre-increment");

  a_vector_load: assert property (@(posedge core_clk)
    disable iff (sys_rst) irq_take |=>
      fetch_addr == 16'h0003 + 16'h0008 * 16'($past(irq_src)))
    else $error("interrupt vector wrong");

  a_code_read_only: assert property (@(posedge core_clk)
    disable iff (sys_rst) (code_we_req && !flash_prog) |->
      !code_we ##1 code_wr_refused)
    else $error("code write passed outside programming");

  a_bank_select: assert property (@(posedge core_clk)
    disable iff (sys_rst)
    (reg_req.en && reg_req.we && !push && !dir_req.en) |=>
      ram_r[{3'h0, $past(flags_r[4:3]), $past(reg_req.idx)}]
        == $past(reg_req.wdata))
    else $error("bank register landed wrong");

  a_bit_area: assert property (@(posedge core_clk)
    disable iff (sys_rst)
    (bit_req.en && bit_req.we && !bit_req.addr[7] && !push &&
     !dir_req.en && !ind_req.en && !reg_req.en) |=>
      ram_r[8'h20 + {4'h0, $past(bit_req.addr[6:3])}]
        [$past(bit_req.addr[2:0])] == $past(bit_req.val))
    else $error("bit write landed wrong");

  a_carry_wins: assert property (@(posedge core_clk)
    disable iff (sys_rst) alu_flags.cy_upd |=>
      flags_r[7] == $past(alu_flags.cy))
    else $error("carry not captured");

  a_ov_capture: assert property (@(posedge core_clk)
    disable iff (sys_rst) alu_flags.ov_upd |=>
      flags_r[2] == $past(alu_flags.ov))
    else $error("signed range flag not captured");

  a_parity_read: assert property (@(posedge core_clk)
    disable iff (sys_rst)
    (dir_req.en && !dir_req.we && dir_req.addr == 8'hd0) |=>
      dir_rdata[0] == ^$past(acc_r))
    else $error("parity read wrong");

  a_pair_write: assert property (@(posedge core_clk)
    disable iff (sys_rst) ab_wr |=> {aux_r, acc_r} == $past(ab_wdata))
    else $error("paired write wrong");

  a_indirect_ram: assert property (@(posedge core_clk)
    disable iff (sys_rst)
    (ind_req.en && ind_req.we && ind_req.addr[7] && !push &&
     !dir_req.en) |=>
      ram_r[$past(ind_req.addr)] == $past(ind_req.wdata) &&
      $stable(acc_r) && $stable(sp_r))
    else $error("indirect access reached special registers");

endmodule

/* testbench.sv */
// Self-checking testbench for the core register file and memory map
`include "mcu_core_regs.svh"
module testbench
  import mcu_core_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  localparam logic [1:0] sel_dir = 2'd0;
  localparam logic [1:0] sel_ind = 2'd1;
  localparam logic [1:0] sel_reg = 2'd2;
  localparam logic [1:0] sel_bit = 2'd3;

  logic        core_clk = 1'b0;
  logic        sys_rst  = 1'b1;
  byte_req_t   dir_req  = '0;
  byte_req_t   ind_req  = '0;
  reg_req_t    reg_req  = '0;
  bit_req_t    bit_req  = '0;
  logic        push     = 1'b0;
  logic        pop      = 1'b0;
  logic [7:0]  push_data = 8'h00;
  logic        acc_wr   = 1'b0;
  logic [7:0]  acc_wdata = 8'h00;
  logic        ab_wr    = 1'b0;
  logic [15:0] ab_wdata = 16'h0000;
  alu_flags_t  alu_flags = '0;
  logic        ext_data_pointer_inc = 1'b0;
  logic        pc_inc   = 1'b0;
  logic        pc_load  = 1'b0;
  logic [15:0] pc_load_addr = 16'h0000;
  logic        irq_take = 1'b0;
  logic [2:0]  irq_src  = 3'h0;
  logic        flash_prog = 1'b0;
  logic        code_we_req = 1'b0;
  logic [7:0]  dir_rdata, ind_rdata, reg_rdata, pop_data, ext_page;
  logic        bit_rdata, code_we, code_wr_refused;
  logic        main_in_data, sec_in_data;
  logic [15:0] fetch_addr, ext_data_addr;
  int          bad_count = 0;
  int          samples_checked = 0;

  always #20 core_clk = ~core_clk;

  mcu_core_memory_and_registers uut (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .dir_req(dir_req), .ind_req(ind_req), .reg_req(reg_req),
    .bit_req(bit_req), .dir_rdata(dir_rdata), .ind_rdata(ind_rdata),
    .reg_rdata(reg_rdata), .bit_rdata(bit_rdata),
    .push(push), .pop(pop), .push_data(push_data), .pop_data(pop_data),
    .acc_wr(acc_wr), .acc_wdata(acc_wdata), .ab_wr(ab_wr),
    .ab_wdata(ab_wdata), .alu_flags(alu_flags), .ext_data_pointer_inc(ext_data_pointer_inc),
    .pc_inc(pc_inc), .pc_load(pc_load), .pc_load_addr(pc_load_addr),
    .irq_take(irq_take), .irq_src(irq_src), .flash_prog(flash_prog),
    .code_we_req(code_we_req), .code_we(code_we),
    .code_wr_refused(code_wr_refused), .fetch_addr(fetch_addr),
    .ext_data_addr(ext_data_addr), .ext_page(ext_page),
    .main_in_data(main_in_data), .sec_in_data(sec_in_data)
  );

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One request, held across its taking edge, result read after it
  task automatic xfer(input logic [1:0] sel, input logic we,
                      input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge core_clk);
    case (sel)
      sel_dir: dir_req <= '{1'b1, we, a, d};
      sel_ind: ind_req <= '{1'b1, we, a, d};
      sel_reg: reg_req <= '{1'b1, we, a[2:0], d};
      default: bit_req <= '{1'b1, we, a, d[0]};
    endcase
    @(posedge core_clk);
    dir_req.en <= 1'b0;
    ind_req.en <= 1'b0;
    reg_req.en <= 1'b0;
    bit_req.en <= 1'b0;
    #1;
    case (sel)
      sel_dir: q = dir_rdata;
      sel_ind: q = ind_rdata;
      sel_reg: q = reg_rdata;
      default: q = {7'h00, bit_rdata};
    endcase
  endtask

  task automatic wr(input logic [1:0] sel, input logic [7:0] a,
                    input logic [7:0] d);
    logic [7:0] q;
    xfer(sel, 1'b1, a, d, q);
  endtask

  task automatic rd(input string what, input logic [1:0] sel,
                    input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    xfer(sel, 1'b0, a, 8'h00, q);
    check(what, {8'h00, q}, {8'h00, exp});
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Hang guard well above the whole sequence
  initial begin
    #4000000;
    bad_count++;
    print_verdict();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    #1;
    check("fetch", fetch_addr, 16'h0000);
    rd("sp_reset", sel_dir, `SFR_STACK, 8'h07);
    @(posedge core_clk);
    push <= 1'b1;
    push_data <= 8'h55;
    @(posedge core_clk);
    push <= 1'b0;
    rd("sp_push", sel_dir, `SFR_STACK, 8'h08);
    rd("ram_08", sel_ind, 8'h08, 8'h55);
    @(posedge core_clk);
    pop <= 1'b1;
    @(posedge core_clk);
    pop <= 1'b0;
    #1;
    check("pop_data", {8'h00, pop_data}, 16'h0055);
    rd("sp_pop", sel_dir, `SFR_STACK, 8'h07);
    // Wrap at the top of RAM, no overflow stop
    wr(sel_dir, `SFR_STACK, 8'hff);
    @(posedge core_clk);
    push <= 1'b1;
    push_data <= 8'haa;
    @(posedge core_clk);
    push <= 1'b0;
    rd("sp_wrap", sel_dir, `SFR_STACK, 8'h00);
    rd("ram_00", sel_ind, 8'h00, 8'haa);
    // Upper half: indirect reaches RAM, direct reaches special regs
    wr(sel_ind, 8'h90, 8'ha5);
    wr(sel_dir, 8'h90, 8'h77);
    rd("ind_90", sel_ind, 8'h90, 8'ha5);
    rd("dir_90", sel_dir, 8'h90, 8'h00);
    wr(sel_dir, 8'h30, 8'h3c);
    rd("ram_30", sel_ind, 8'h30, 8'h3c);
    // Every bank, one register each
    for (int b = 0; b < 4; b++) begin
      wr(sel_dir, `SFR_FLAGS, 8'(b << 3));
      wr(sel_reg, 8'h02, 8'h40 + 8'(b));
      rd("bank_reg", sel_ind, 8'(8 * b + 2), 8'h40 + 8'(b));
      rd("reg_back", sel_reg, 8'h02, 8'h40 + 8'(b));
    end
    wr(sel_dir, `SFR_FLAGS, 8'h00);
    // Bit area: bits of bytes 21h and 2Fh written and read
    wr(sel_ind, 8'h21, 8'h00);
    wr(sel_ind, 8'h2f, 8'h00);
    wr(sel_bit, 8'h0b, 8'h01);
    wr(sel_bit, 8'h7f, 8'h01);
    rd("ram_21", sel_ind, 8'h21, 8'h08);
    rd("ram_2f", sel_ind, 8'h2f, 8'h80);
    rd("bit_7f", sel_bit, 8'h7f, 8'h01);
    // Accumulator with aux as one 16-bit pair, parity follows
    @(posedge core_clk);
    ab_wr <= 1'b1;
    ab_wdata <= 16'h1234;
    @(posedge core_clk);
    ab_wr <= 1'b0;
    rd("acc", sel_dir, `SFR_ACC, 8'h34);
    rd("aux", sel_dir, `SFR_AUX, 8'h12);
    rd("par_odd", sel_dir, `SFR_FLAGS, 8'h01);
    @(posedge core_clk);
    acc_wr <= 1'b1;
    acc_wdata <= 8'h03;
    @(posedge core_clk);
    acc_wr <= 1'b0;
    rd("par_even", sel_dir, `SFR_FLAGS, 8'h00);
    wr(sel_bit, `SFR_ACC | 8'h03, 8'h01);
    rd("acc_bit", sel_dir, `SFR_ACC, 8'h0b);
    rd("acc_bit_rd", sel_bit, `SFR_ACC | 8'h01, 8'h01);
    // ALU flag updates; acc 0bh has odd ones so parity is set
    @(posedge core_clk);
    alu_flags <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
    @(posedge core_clk);
    alu_flags <= '0;
    rd("alu_flags", sel_dir, `SFR_FLAGS, 8'hc5);
    // Data pointer halves and increment carry across them
    wr(sel_dir, `SFR_DP_LOW, 8'hff);
    wr(sel_dir, `SFR_DP_HIGH, 8'h12);
    check("ext_data_pointer", ext_data_addr, 16'h12ff);
    @(posedge core_clk);
    ext_data_pointer_inc <= 1'b1;
    @(posedge core_clk);
    ext_data_pointer_inc <= 1'b0;
    #1;
    check("ext_data_pointer_inc", ext_data_addr, 16'h1300);
    check("fetch_apart", fetch_addr, 16'h0000);
    // Vector per source, then vector space used as plain code
    for (int s = 0; s < 8; s++) begin
      @(posedge core_clk);
      irq_take <= 1'b1;
      irq_src <= 3'(s);
      @(posedge core_clk);
      irq_take <= 1'b0;
      #1;
      check("vector", fetch_addr, 16'h0003 + 16'(8 * s));
    end
    @(posedge core_clk);
    pc_load <= 1'b1;
    pc_load_addr <= 16'h000b;
    @(posedge core_clk);
    pc_load <= 1'b0;
    pc_inc <= 1'b1;
    @(posedge core_clk);
    pc_inc <= 1'b0;
    #1;
    check("vec_plain", fetch_addr, 16'h000c);
    // Code writes refused outside programming
    @(posedge core_clk);
    code_we_req <= 1'b1;
    #1;
    check("code_we_off", {15'h0, code_we}, 16'h0000);
    @(posedge core_clk);
    code_we_req <= 1'b0;
    flash_prog <= 1'b1;
    #1;
    check("refused", {15'h0, code_wr_refused}, 16'h0001);
    @(posedge core_clk);
    code_we_req <= 1'b1;
    #1;
    check("code_we_on", {15'h0, code_we}, 16'h0001);
    @(posedge core_clk);
    code_we_req <= 1'b0;
    #1;
    check("not_refused", {15'h0, code_wr_refused}, 16'h0000);
    // Page and array mapping controls
    wr(sel_dir, `SFR_PAGE, 8'h5a);
    check("page", {8'h00, ext_page}, 16'h005a);
    wr(sel_dir, `SFR_MAP, 8'h02);
    check("map", {14'h0, sec_in_data, main_in_data}, 16'h0002);
    wr(sel_dir, `SFR_MAP, 8'h01);
    check("map", {14'h0, sec_in_data, main_in_data}, 16'h0001);
    print_verdict();
  end
endmodule
